// [pkg/qdc_map.svh]
// Register map, field positions and frame length for the quad converter control block
// How it works
// R1: With the read-back select bit clear, a channel read returns its input data register.
// R2: With the read-back select bit set, a channel read returns its active output latch.
// R3: With the load pin high, setting the software load bit copies every written input register into its latch together.
// R4: A load event updates only the channels written since the previous load event.
// R5: The software load bit clears itself once its latch update is done.
// R6: While the load pin is low the software load bit is ignored.
// R7: Writing one to the software reset bit resets every register the reset input does, except the pin synchronisers.
// R8: The software reset bit reads zero again once its reset has completed.
// R9: While the group A power-down bit is set, channels 0 and 1 are powered down.
// R10: While the group B power-down bit is set, channels 2 and 3 are powered down.
// R11: The serial interface and registers keep working while any group is powered down.
// R12: Command bit 10 ignores writes and always reads zero.
// R13: Each access is a 24-bit frame of read flag, four address bits and data, and the frame register clears at reset.
// R14: After a read command the addressed register is shifted out during the next frame.
// R15: Each channel keeps a written-since-update flag, set by a data write and cleared by a load event unless that channel is written in the same cycle.
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH
`define QDC_FRAME_BITS    24
`define QDC_ADDR_CMD      4'h0
`define QDC_ADDR_MON      4'h1
`define QDC_ADDR_CH0      4'h4
`define QDC_CMD_RESET     16'h033c
`define QDC_CMD_WMASK     16'hfbfc
`define QDC_BIT_SRC_SEL   15
`define QDC_BIT_SW_LOAD   14
`define QDC_BIT_SW_RST    13
`define QDC_BIT_PWRDN_A   12
`define QDC_BIT_PWRDN_B   11
`define QDC_BIT_RSVD10    10
`define QDC_BIT_DSDO      7
`define QDC_BIT_NOP       6
`endif

// [pkg/qdc_pkg.sv]
// Types for the quad converter control block
`default_nettype none
package qdc_pkg;
  typedef logic [15:0] qdc_word_t;
  typedef logic [3:0]  qdc_addr_t;
  typedef logic [3:0]  qdc_chmask_t;
endpackage
`default_nettype wire

// [src/qdc_ctrl.sv]
// Serial command and load control for a quad converter
`include "qdc_map.svh"
`default_nettype none
module qdc_ctrl (
  input  wire logic          i_ref_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_ce,
  input  wire logic          i_sclk,
  input  wire logic          i_cs_n,
  input  wire logic          i_sdi,
  input  wire logic          i_load_pin_n,
  output logic               o_sdo,
  output logic               o_sdo_oe,
  output qdc_pkg::qdc_word_t o_cmd,
  output qdc_pkg::qdc_word_t o_latch [4],
  output logic               o_group_a_powerdown,
  output logic               o_group_b_powerdown
);
  import qdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; ordered sclk, cs_n, sdi, load
  logic [3:0] pin_raw;
  logic [3:0] pin_s;
  logic [3:0] pin_rv;
  assign pin_raw = {i_load_pin_n, i_sdi, i_cs_n, i_sclk};
  // Reset values match the idle pin levels, so no false edge follows reset
  assign pin_rv  = 4'ha;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      qdc_sync u_sync (
        .i_clk     (i_ref_clk),
        .i_rst     (i_sys_rst),
        .i_ce      (i_ce),
        .i_rst_val (pin_rv[g]),
        .i_d       (pin_raw[g]),
        .o_q       (pin_s[g])
      );
    end
  endgenerate

  wire sclk_s = pin_s[0];
  wire cs_n_s = pin_s[1];
  wire sdi_s  = pin_s[2];
  wire load_s = pin_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic                          sclk_d_r;
  logic                          load_d_r;
  logic                          cs_d_r;
  logic [`QDC_FRAME_BITS-1:0]    shift_r;
  logic [`QDC_FRAME_BITS-1:0]    out_r;
  logic [4:0]                    bitcnt_r;
  qdc_addr_t                     rd_addr_r;
  qdc_word_t                     cmd_r;
  qdc_word_t                     in_r    [4];
  qdc_word_t                     latch_r [4];
  qdc_chmask_t                   dirty_r;
  logic                          sw_rst_r;

  // Software reset folds into the same path as the reset input
  // R7: software reset as the reset input, bar the synchronisers
  wire rst_all = i_sys_rst | sw_rst_r;

  wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  wire frame_end = cs_n_s & ~cs_d_r;
  wire full_frame = (bitcnt_r == 5'(`QDC_FRAME_BITS));

  // R13: 24-bit frame fields
  wire        f_read  = shift_r[23];
  qdc_addr_t  f_addr;
  qdc_word_t  f_data;
  assign f_addr = shift_r[19:16];
  assign f_data = shift_r[15:0];
  wire        do_wr = frame_end & full_frame & ~f_read;
  wire        do_rd = frame_end & full_frame & f_read;
  wire        wr_cmd = do_wr & (f_addr == `QDC_ADDR_CMD);
  wire        wr_ch  = do_wr & (f_addr[3:2] == 2'b01);
  wire [1:0]  ch_sel = f_addr[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Load events
  // R6: pin low masks soft load
  wire pin_load  = ~load_s & load_d_r;
  // R3: soft load only when pin high
  wire soft_load = cmd_r[`QDC_BIT_SW_LOAD] & load_s;
  wire load_evt  = pin_load | soft_load;

  // R12: bit 10 and reserved bits masked
  qdc_word_t cmd_wr;
  assign cmd_wr = f_data & `QDC_CMD_WMASK & ~(16'h1 << `QDC_BIT_NOP);

  ////////////////////////////////////////////////////////////////////////////
  // Read-back mux
  qdc_word_t rd_word;
  wire [1:0] rd_ch = rd_addr_r[1:0];
  wire       rd_is_ch = (rd_addr_r[3:2] == 2'b01);
  // R1: select bit clear gives input
  // R2: select bit set gives latch
  assign rd_word = (rd_addr_r == `QDC_ADDR_CMD) ? cmd_r :
                   !rd_is_ch                    ? 16'h0000 :
                   cmd_r[`QDC_BIT_SRC_SEL]      ? latch_r[rd_ch] : in_r[rd_ch];

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter, runs regardless of power-down
  // R11: interface stays live
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      load_d_r <= 1'b1;
      shift_r  <= 24'h000000;
      bitcnt_r <= 5'h00;
    end else if (i_ce) begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_n_s;
      load_d_r <= load_s;
      if (cs_n_s) begin
        bitcnt_r <= 5'h00;
      end else if (sclk_rise) begin
        shift_r  <= {shift_r[22:0], sdi_s};
        if (!full_frame) begin
          bitcnt_r <= bitcnt_r + 5'h01;
        end
      end
    end
  end

  // R14: read data in next frame
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      rd_addr_r <= 4'h0;
      out_r     <= 24'h000000;
    end else if (i_ce) begin
      if (do_rd) begin
        rd_addr_r <= f_addr;
      end
      if (cs_n_s) begin
        out_r <= {4'h0, rd_addr_r, rd_word};
      end else if (sclk_fall) begin
        out_r <= {out_r[22:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command register
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sw_rst_r <= 1'b0;
    end else if (i_ce) begin
      // R8: reset bit self-clears
      sw_rst_r <= sw_rst_r ? 1'b0 : (wr_cmd & f_data[`QDC_BIT_SW_RST]);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      cmd_r <= `QDC_CMD_RESET;
    end else if (i_ce) begin
      if (wr_cmd) begin
        cmd_r <= cmd_wr & ~(16'h1 << `QDC_BIT_SW_RST);
      end else if (soft_load || (cmd_r[`QDC_BIT_SW_LOAD] && !load_s)) begin
        // R5: load bit self-clears
        cmd_r[`QDC_BIT_SW_LOAD] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel data, latches and dirty flags
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      dirty_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        in_r[i]    <= 16'h0000;
        latch_r[i] <= 16'h0000;
      end
    end else if (i_ce) begin
      for (int i = 0; i < 4; i++) begin
        // R4: only written channels load
        if (load_evt && dirty_r[i]) begin
          latch_r[i] <= in_r[i];
        end
        // R15: write sets, load clears
        if (wr_ch && ch_sel == 2'(i)) begin
          in_r[i]    <= f_data & 16'hfffc;
          dirty_r[i] <= 1'b1;
        end else if (load_evt) begin
          dirty_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge i_ref_clk) begin
    if (rst_all) begin
      o_sdo               <= 1'b0;
      o_sdo_oe            <= 1'b0;
      o_cmd               <= `QDC_CMD_RESET;
      o_group_a_powerdown <= 1'b0;
      o_group_b_powerdown <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        o_latch[i] <= 16'h0000;
      end
    end else if (i_ce) begin
      o_sdo    <= out_r[23];
      o_sdo_oe <= ~cs_n_s & ~cmd_r[`QDC_BIT_DSDO];
      o_cmd    <= cmd_r;
      // R9: group A power-down
      o_group_a_powerdown <= cmd_r[`QDC_BIT_PWRDN_A];
      // R10: group B power-down
      o_group_b_powerdown <= cmd_r[`QDC_BIT_PWRDN_B];
      for (int i = 0; i < 4; i++) begin
        o_latch[i] <= latch_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_dirty_load(int k);
    dirty_r[k] && load_evt && i_ce;
  endsequence

  a_pwrdn_a_follow: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R9
    i_ce |=> o_group_a_powerdown == $past(cmd_r[`QDC_BIT_PWRDN_A])) else $error("group a power-down mismatch");
  a_pwrdn_b_follow: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R10
    i_ce |=> o_group_b_powerdown == $past(cmd_r[`QDC_BIT_PWRDN_B])) else $error("group b power-down mismatch");
  a_rsvd_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R12
    !cmd_r[`QDC_BIT_RSVD10]) else $error("bit 10 set");
  a_rst_clears: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R8
    sw_rst_r && i_ce |=> !sw_rst_r && cmd_r == `QDC_CMD_RESET) else $error("soft reset stuck");
  a_load_ignored: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R6
    !load_s && !load_d_r && i_ce |=> $stable({latch_r[3], latch_r[2], latch_r[1], latch_r[0]}))
    else $error("soft load while pin low");
  a_load_clears: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R5
    soft_load && i_ce && !wr_cmd |=> !cmd_r[`QDC_BIT_SW_LOAD]) else $error("load bit stuck");
  a_latch_ch0: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R4
    s_dirty_load(0) |=> latch_r[0] == $past(in_r[0])) else $error("latch 0 not updated");
  a_clean_hold: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R4
    !dirty_r[1] && i_ce |=> $stable(latch_r[1])) else $error("clean latch changed");
  a_dirty_clear: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R15
    load_evt && !wr_ch && i_ce |=> dirty_r == 4'h0) else $error("dirty not cleared");
  a_src_select: assert property (@(posedge i_ref_clk) disable iff (rst_all) // R2
    rd_is_ch && cmd_r[`QDC_BIT_SRC_SEL] |-> rd_word == latch_r[rd_ch]) else $error("readback source");
endmodule
`default_nettype wire

// [src/qdc_sync.sv]
// Two-flop synchroniser for one pin level
`default_nettype none
module qdc_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_rst_val,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= i_rst_val;
      o_q    <= i_rst_val;
    end else if (i_ce) begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [testbench/qdc_host.sv]
// Host model that drives serial frames into the control block
`default_nettype none
module qdc_host (
  input  wire logic i_ref_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // Half of the 64 ns link period, ends just after a clock edge
  task automatic half();
    repeat (8) @(posedge i_ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // MSB-first frame, reply sampled before sclk rise
  task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_sdi = tx[i];
      half();
      // Undriven line must not pass for data
      rx = {rx[22:0], i_sdo_oe ? i_sdo : 1'bx};
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    o_cs_n = 1'b1;
    // Data line stale outside frames
    o_sdi  = ~o_sdi;
    repeat (2) half();
  endtask
endmodule
`default_nettype wire

// [testbench/test_quad_dac_command_control.sv]
// Self-checking bench for the quad converter command control block
`default_nettype none
module test_quad_dac_command_control;
  timeunit 1ns;
  timeprecision 100ps;
  import qdc_pkg::*;

  logic        clk, rst, ce, sclk, cs_n, sdi, load_n, sdo, sdo_oe, pwrdn_a, pwrdn_b;
  qdc_word_t   cmd;
  qdc_word_t   latch [4];
  logic [23:0] rx;
  int          fail_count, n_compared;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  qdc_ctrl dut (
    .i_ref_clk          (clk),
    .i_sys_rst          (rst),
    .i_ce               (ce),
    .i_sclk             (sclk),
    .i_cs_n             (cs_n),
    .i_sdi              (sdi),
    .i_load_pin_n       (load_n),
    .o_sdo              (sdo),
    .o_sdo_oe           (sdo_oe),
    .o_cmd              (cmd),
    .o_latch            (latch),
    .o_group_a_powerdown(pwrdn_a),
    .o_group_b_powerdown(pwrdn_b)
  );

  qdc_host host (
    .i_ref_clk(clk),
    .i_sdo    (sdo),
    .i_sdo_oe (sdo_oe),
    .o_sclk   (sclk),
    .o_cs_n   (cs_n),
    .o_sdi    (sdi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input qdc_addr_t a, input qdc_word_t d);
    host.frame({4'h0, a, d}, 24, rx);
  endtask

  // Second read frame clocks out the first one's answer
  task automatic rd(input qdc_addr_t a, input qdc_word_t e);
    host.frame({4'h8, a, 16'h0000}, 24, rx);
    host.frame({4'h8, a, 16'h0000}, 24, rx);
    check(rx, {4'h0, a, e});
  endtask

  task automatic wait_latch(input int ch, input qdc_word_t exp);
    int n;
    n = 0;
    while (latch[ch] !== exp && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({8'h00, latch[ch]}, {8'h00, exp});
    if (n == 40) begin
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    load_n = 1'b1;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    host.half();
    check({8'h00, cmd}, 24'h00033c);
    check({23'h0, sdo_oe}, 24'h000000);
    rd(4'h0, 16'h033c);
    // Reserved bit set on purpose, both groups down
    wr(4'h0, 16'h9c3c);
    check({8'h00, cmd}, 24'h00983c);
    check({22'h0, pwrdn_a, pwrdn_b}, 24'h000003);
    rd(4'h0, 16'h983c);
    wr(4'h4, 16'h1234);
    rd(4'h4, 16'h0000);
    wr(4'h0, 16'h003c);
    check({22'h0, pwrdn_a, pwrdn_b}, 24'h000000);
    rd(4'h4, 16'h1234);
    host.frame(24'h00ffff, 16, rx);
    check({8'h00, cmd}, 24'h00003c);
    // Frozen clock enable lets no frame through
    ce = 1'b0;
    wr(4'h0, 16'h183c);
    ce = 1'b1;
    host.half();
    check({8'h00, cmd}, 24'h00003c);
    check({22'h0, pwrdn_a, pwrdn_b}, 24'h000000);
    // Disabled serial output leaves the reply line undriven
    wr(4'h0, 16'h00bc);
    host.frame({4'h8, 4'h0, 16'h0000}, 24, rx);
    check(rx, 24'hxxxxxx);
    wr(4'h0, 16'h003c);
    wr(4'h5, 16'h5678);
    wr(4'h0, 16'h403c);
    wait_latch(0, 16'h1234);
    wait_latch(1, 16'h5678);
    check({8'h00, latch[2]}, 24'h000000);
    check({8'h00, cmd}, 24'h00003c);
    // Pin held low masks the software strobe
    load_n = 1'b0;
    host.half();
    wr(4'h7, 16'h1110);
    wr(4'h0, 16'h403c);
    check({8'h00, latch[3]}, 24'h000000);
    check({8'h00, cmd}, 24'h00003c);
    load_n = 1'b1;
    host.half();
    load_n = 1'b0;
    wait_latch(3, 16'h1110);
    load_n = 1'b1;
    wr(4'h0, 16'h203c);
    check({8'h00, cmd}, 24'h00033c);
    wait_latch(0, 16'h0000);
    rd(4'h0, 16'h033c);
    report_and_stop();
  end
endmodule
`default_nettype wire
